// ===== shared/wdct_pkg.sv
// constants shared by the watchdog and dual countdown timer block
package wdct_pkg;
   // mode register bit positions (both timers)
   localparam int MODE_CLK_SEL = 0;
   localparam int MODE_B_EXT = 1;
   localparam int MODE_B_TONE = 2;
   localparam int MODE_RUN = 3;
   localparam logic [3:0] MODE_RST = 4'h0;
   // event flag layout; only timer bits live in this block
   localparam logic [7:0] EVF_TA_MASK = 8'h02;
   localparam logic [7:0] EVF_TB_MASK = 8'h80;
   localparam logic [7:0] EVF_IMPL_MASK = 8'h82;
   localparam logic [7:0] EVF_RST = 8'h00;
   // parameter flag bit that slows the watchdog input
   localparam int PMF_WDT_SLOW = 3;
   localparam logic [3:0] PMF_RST = 4'h0;
   // counter values
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] CNT_ZERO = 8'h00;
   localparam logic [7:0] CNT_STEP = 8'h01;
   localparam logic [3:0] WDT_RST = 4'h0;
   localparam logic [3:0] WDT_MAX = 4'hf;
   localparam logic [3:0] WDT_STEP = 4'h1;
   // prescaler chain taps: a tap fires when its low bits are all ones
   localparam int PRE_BITS = 14;
   localparam logic [13:0] PRE_RST = 14'h0000;
   localparam logic [13:0] PRE_STEP = 14'h0001;
   localparam logic [13:0] TAP_DIV4 = 14'h0003;
   localparam logic [13:0] TAP_DIV64 = 14'h003f;
   localparam logic [13:0] TAP_DIV1024 = 14'h03ff;
   localparam logic [13:0] TAP_DIV16384 = 14'h3fff;
   // periods of the slow watchdog input from clear to the earliest overflow
   localparam int WDT_MIN_OVF_TICKS = 15;
endpackage

// ===== hw/wdct_prescaler.sv
// free-running prescaler chain giving one-cycle taps at fosc/4, /64, /1024, /16384
`timescale 1ns/100ps
module wdct_prescaler
   import wdct_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   output logic tick_div4_o,
   output logic tick_div64_o,
   output logic tick_div1024_o,
   output logic tick_div16384_o
);
   typedef struct packed {
      logic [PRE_BITS-1:0] cnt;
   } wdct_pre_s;

   wdct_pre_s q, d;

   function automatic logic tap_hit(input logic [13:0] cnt, input logic [13:0] mask);
      return (cnt & mask) == mask;
   endfunction

   // one shared chain, so every tap keeps a fixed phase to the others
   always_comb begin
      d = q;
      d.cnt = q.cnt + PRE_STEP; // R25
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{cnt: PRE_RST};
      end else begin
         q <= d;
      end
   end

   // taps decode straight from the chain register
   assign tick_div4_o = tap_hit(q.cnt, TAP_DIV4); // R25
   assign tick_div64_o = tap_hit(q.cnt, TAP_DIV64);
   assign tick_div1024_o = tap_hit(q.cnt, TAP_DIV1024);
   assign tick_div16384_o = tap_hit(q.cnt, TAP_DIV16384);
endmodule // wdct_prescaler

// ===== hw/wdct_timers.sv
// watchdog, one-shot timer a and auto-reload timer b with tone output
// Summary of operation
// R01 - watchdog is a 4-bit up-counter, active only when its option bit is one
// R02 - watchdog overflow produces a full chip reset
// R03 - watchdog counts fosc/1024 after reset, fosc/16384 while parameter flag bit 3 set
// R04 - clear instruction zeroes the watchdog; software must clear it before overflow
// R05 - minimum clear-to-overflow time is 15 slow input periods
// R06 - option bit zero disables the watchdog; it never resets the chip
// R07 - timer a nibble load stops counting, clears its run bit, loads the nibble
// R08 - writing timer a run bit one clears event bit 1 and starts counting
// R09 - timer a passing zero to ffh stops and sets event bit 1 (one-shot)
// R10 - timer a underflow requests interrupt via enable bit 1, hold release via bit 1
// R11 - timer a clock is fosc/4 with mode bit 0 clear, fosc/1024 when set
// R12 - timer a run bit zero halts counting, one allows counting
// R13 - timer b clock: bit 0 picks fosc or fosc/64, bit 1 picks external pin
// R14 - external source decrements timer b on each falling edge of the count pin
// R15 - timer b nibble write updates only the reload buffer and clears run bit
// R16 - setting timer b run bit copies buffer to counter, starts, clears event bit 7
// R17 - immediate load clears event bit 7, loads buffer and counter, then runs
// R18 - timer b reaching ffh sets event bit 7, reloads from buffer, keeps counting
// R19 - timer b underflow requests interrupt via enable bit 7, hold release via bit 7
// R20 - mode bit 2 set sends timer b tone to the pin, else the tone generator
// R21 - timer b run bit zero halts counting, one enables counting
// R22 - both mode registers are four bits wide and cannot be read back
// R23 - event flags are read-only, set by hardware, cleared by instruction or acceptance
// R24 - tone output toggles on every timer b underflow, giving an even square wave
// R25 - watchdog and timer clocks are taps of one shared prescaler chain; timer b's fosc and external sources bypass the chain
`timescale 1ns/100ps
module wdct_timers
   import wdct_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wdt_option_i,
   input wire logic watchdog_clear_instr_i,
   input wire logic pmf_set_i,
   input wire logic pmf_clr_i,
   input wire logic [3:0] pmf_mask_i,
   input wire logic mode_a_we_i,
   input wire logic mode_b_we_i,
   input wire logic [3:0] mode_wdata_i,
   input wire logic ta_nib_lo_we_i,
   input wire logic ta_nib_hi_we_i,
   input wire logic tb_nib_lo_we_i,
   input wire logic tb_nib_hi_we_i,
   input wire logic [3:0] nib_data_i,
   input wire logic tb_imm_we_i,
   input wire logic [7:0] tb_imm_data_i,
   input wire logic event_clear_instr_i,
   input wire logic [7:0] evf_clr_mask_i,
   input wire logic [7:0] irq_ack_i,
   input wire logic [7:0] irq_enable_flags_i,
   input wire logic [7:0] hold_release_enable_i,
   input wire logic ext_count_input_i,
   input wire logic tone_gen_i,
   output logic chip_reset_o,
   output logic [7:0] event_flags_o,
   output logic [7:0] irq_pending_o,
   output logic [7:0] hold_release_o,
   output logic tone_output_pin_o
);
   typedef struct packed {
      logic [3:0] mode_a;
      logic [7:0] cnt_a;
      logic [3:0] mode_b;
      logic [7:0] buf_b;
      logic [7:0] cnt_b;
      logic [7:0] event_flags;
      logic [3:0] parameter_flags;
      logic [3:0] wdt;
      logic ext_prev;
      logic tone;
      logic tone_pin;
      logic chip_rst;
   } wdct_core_s;

   wdct_core_s q, d;
   logic tick4, tick64, tick1024, tick16384;
   logic ta_tick, tb_tick, wd_tick, ta_uf, tb_uf;
   logic [7:0] evf_set, evf_clr;
   logic [8:0] dec_a, dec_b;

   // borrow in bit 8, decremented value below it
   function automatic logic [8:0] dec8(input logic [7:0] v);
      return {v == CNT_ZERO, v - CNT_STEP};
   endfunction

   wdct_prescaler u_pre (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_div4_o(tick4),
      .tick_div64_o(tick64),
      .tick_div1024_o(tick1024),
      .tick_div16384_o(tick16384)
   );

   // all next-state logic; within one timer a load beats a mode write beats counting
   always_comb begin
      d = q;
      evf_set = EVF_RST;
      evf_clr = irq_ack_i; // R23
      ta_uf = 1'b0;
      tb_uf = 1'b0;
      dec_a = dec8(q.cnt_a);
      dec_b = dec8(q.cnt_b);
      if (event_clear_instr_i) begin
         evf_clr = evf_clr | evf_clr_mask_i; // R23
      end
      // clock selection from the shared chain, or plain fosc and the count pin for timer b
      ta_tick = q.mode_a[MODE_CLK_SEL] ? tick1024 : tick4; // R11
      if (q.mode_b[MODE_B_EXT]) begin
         tb_tick = q.ext_prev & ~ext_count_input_i; // R14
      end else begin
         tb_tick = q.mode_b[MODE_CLK_SEL] ? tick64 : 1'b1; // R13
      end
      d.ext_prev = ext_count_input_i;
      wd_tick = q.parameter_flags[PMF_WDT_SLOW] ? tick16384 : tick1024; // R03

      // timer a: one-shot down-counter
      if (ta_nib_lo_we_i | ta_nib_hi_we_i) begin
         d.mode_a[MODE_RUN] = 1'b0; // R07
         if (ta_nib_lo_we_i) begin
            d.cnt_a[3:0] = nib_data_i; // R07
         end
         if (ta_nib_hi_we_i) begin
            d.cnt_a[7:4] = nib_data_i;
         end
      end else if (mode_a_we_i) begin
         d.mode_a = mode_wdata_i; // R22
         if (mode_wdata_i[MODE_RUN]) begin
            evf_clr = evf_clr | EVF_TA_MASK; // R08
         end
      end else if (q.mode_a[MODE_RUN] && ta_tick) begin // R12
         d.cnt_a = dec_a[7:0];
         if (dec_a[8]) begin
            ta_uf = 1'b1;
            d.mode_a[MODE_RUN] = 1'b0; // R09
            evf_set = evf_set | EVF_TA_MASK; // R09
         end
      end

      // timer b: auto-reload down-counter
      if (tb_imm_we_i) begin
         d.buf_b = tb_imm_data_i; // R17
         d.cnt_b = tb_imm_data_i;
         d.mode_b[MODE_RUN] = 1'b1; // R17
         evf_clr = evf_clr | EVF_TB_MASK; // R17
      end else if (tb_nib_lo_we_i | tb_nib_hi_we_i) begin
         d.mode_b[MODE_RUN] = 1'b0; // R15
         if (tb_nib_lo_we_i) begin
            d.buf_b[3:0] = nib_data_i; // R15
         end
         if (tb_nib_hi_we_i) begin
            d.buf_b[7:4] = nib_data_i;
         end
      end else if (mode_b_we_i) begin
         d.mode_b = mode_wdata_i; // R22
         if (mode_wdata_i[MODE_RUN]) begin
            d.cnt_b = q.buf_b; // R16
            evf_clr = evf_clr | EVF_TB_MASK; // R16
         end
      end else if (q.mode_b[MODE_RUN] && tb_tick) begin // R21
         if (dec_b[8]) begin
            tb_uf = 1'b1;
            d.cnt_b = q.buf_b; // R18
            evf_set = evf_set | EVF_TB_MASK; // R18
         end else begin
            d.cnt_b = dec_b[7:0];
         end
      end

      // tone flip-flop halves the underflow rate for an even duty cycle
      if (tb_uf) begin
         d.tone = ~q.tone; // R24
      end
      d.tone_pin = d.mode_b[MODE_B_TONE] ? d.tone : tone_gen_i; // R20

      // a hardware set in the same cycle as a clear is kept
      d.event_flags = ((q.event_flags & ~evf_clr) | evf_set) & EVF_IMPL_MASK; // R23

      // parameter flags: set then clear by mask
      if (pmf_set_i) begin
         d.parameter_flags = d.parameter_flags | pmf_mask_i; // R03
      end
      if (pmf_clr_i) begin
         d.parameter_flags = d.parameter_flags & ~pmf_mask_i; // R03
      end

      // watchdog; the chain is not cleared, so a clear costs up to one input period
      d.chip_rst = 1'b0;
      if (watchdog_clear_instr_i) begin
         d.wdt = WDT_RST; // R04
      end else if (wdt_option_i && wd_tick) begin // R01 R06
         if (q.wdt == WDT_MAX) begin
            d.wdt = WDT_RST;
            d.chip_rst = 1'b1; // R02 R05
         end else begin
            d.wdt = q.wdt + WDT_STEP; // R01
         end
      end
   end

   // single state register; the mode registers never leave this module
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{mode_a: MODE_RST, cnt_a: CNT_RST, mode_b: MODE_RST, buf_b: CNT_RST,
                cnt_b: CNT_RST, event_flags: EVF_RST, parameter_flags: PMF_RST, wdt: WDT_RST,
                ext_prev: 1'b1, tone: 1'b0, tone_pin: 1'b0, chip_rst: 1'b0};
      end else begin
         q <= d;
      end
   end

   // request lines combine the flags with the enables held outside
   assign chip_reset_o = q.chip_rst;
   assign event_flags_o = q.event_flags;
   assign irq_pending_o = q.event_flags & irq_enable_flags_i; // R10 R19
   assign hold_release_o = q.event_flags & hold_release_enable_i; // R10 R19
   assign tone_output_pin_o = q.tone_pin;

   // ---- checks ----
   default clocking dflt_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic ta_free, tb_free;
   assign ta_free = !(ta_nib_lo_we_i | ta_nib_hi_we_i | mode_a_we_i);
   assign tb_free = !(tb_imm_we_i | tb_nib_lo_we_i | tb_nib_hi_we_i | mode_b_we_i);

   sequence reset_pulse_s;
      chip_reset_o ##1 !chip_reset_o;
   endsequence

   sequence tb_reloaded_s;
      q.event_flags[7] && q.mode_b[MODE_RUN] && (q.cnt_b == $past(q.buf_b));
   endsequence

   ta_one_shot_a: assert property (q.mode_a[MODE_RUN] && ta_tick && q.cnt_a == CNT_ZERO
         && ta_free |=> !q.mode_a[MODE_RUN] && q.event_flags[1] && q.cnt_a == 8'hff) // R09
      else $error("timer a did not stop with its flag at ffh");

   ta_load_stop_a: assert property ((ta_nib_lo_we_i || ta_nib_hi_we_i)
         |=> !q.mode_a[MODE_RUN] ##1 (!q.mode_a[MODE_RUN] || $past(mode_a_we_i))) // R07
      else $error("timer a kept running after a nibble load");

   ta_start_a: assert property (mode_a_we_i && mode_wdata_i[MODE_RUN] && !ta_nib_lo_we_i
         && !ta_nib_hi_we_i |=> q.mode_a[MODE_RUN] && $stable(q.cnt_a)) // R08
      else $error("timer a did not start on a run write");

   tb_reload_a: assert property (q.mode_b[MODE_RUN] && tb_tick && q.cnt_b == CNT_ZERO
         && tb_free |=> tb_reloaded_s) // R18
      else $error("timer b did not reload on underflow");

   tb_imm_load_a: assert property (tb_imm_we_i |=> q.mode_b[MODE_RUN]
         && q.cnt_b == $past(tb_imm_data_i) && q.buf_b == q.cnt_b) // R17
      else $error("timer b immediate load went wrong");

   tb_nib_stop_a: assert property ((tb_nib_lo_we_i || tb_nib_hi_we_i) && !tb_imm_we_i
         |=> !q.mode_b[MODE_RUN] && $stable(q.cnt_b)) // R15
      else $error("timer b nibble write touched the counter or run bit");

   tone_toggle_a: assert property (tb_uf |=> q.tone != $past(q.tone)) // R24
      else $error("tone did not toggle on underflow");

   wdt_overflow_a: assert property (wdt_option_i && wd_tick && q.wdt == WDT_MAX
         && !watchdog_clear_instr_i |=> reset_pulse_s) // R02
      else $error("watchdog overflow gave no single reset pulse");

   wdt_disabled_a: assert property (!$past(wdt_option_i) |-> !chip_reset_o) // R06
      else $error("disabled watchdog reset the chip");

   wdt_clear_a: assert property (watchdog_clear_instr_i |=> q.wdt == WDT_RST
         ##1 q.wdt <= WDT_STEP) // R04
      else $error("watchdog clear did not zero the counter");

   evf_set_wins_a: assert property (ta_uf |=> q.event_flags[1]) // R23
      else $error("timer a event was lost against a clear");
endmodule // wdct_timers

// ===== sim/wdct_tb.sv
// self-checking bench for the watchdog and dual countdown timers
`timescale 1ns/100ps
module testbench
   import wdct_pkg::*;
;
   logic clk_i, rst_i, wdt_option_i, watchdog_clear_instr_i, pmf_set_i, pmf_clr_i;
   logic mode_a_we_i, mode_b_we_i, ta_nib_lo_we_i, ta_nib_hi_we_i, tb_nib_lo_we_i;
   logic tb_nib_hi_we_i, tb_imm_we_i, event_clear_instr_i, ext_count_input_i, tone_gen_i;
   logic chip_reset_o, tone_output_pin_o;
   logic [3:0] pmf_mask_i, mode_wdata_i, nib_data_i;
   logic [7:0] tb_imm_data_i, evf_clr_mask_i, irq_ack_i, irq_enable_flags_i, p;
   logic [7:0] hold_release_enable_i, event_flags_o, irq_pending_o, hold_release_o;
   logic [31:0] lfsr_q = 32'h0001_767b;
   logic [31:0] r;
   int n_mismatch = 0, n_tests = 0, n_rst = 0, n, k;

   wdct_timers dut (.clk_i, .rst_i, .wdt_option_i, .watchdog_clear_instr_i, .pmf_set_i,
      .pmf_clr_i, .pmf_mask_i, .mode_a_we_i, .mode_b_we_i, .mode_wdata_i, .ta_nib_lo_we_i,
      .ta_nib_hi_we_i, .tb_nib_lo_we_i, .tb_nib_hi_we_i, .nib_data_i, .tb_imm_we_i,
      .tb_imm_data_i, .event_clear_instr_i, .evf_clr_mask_i, .irq_ack_i, .irq_enable_flags_i,
      .hold_release_enable_i, .ext_count_input_i, .tone_gen_i, .chip_reset_o, .event_flags_o,
      .irq_pending_o, .hold_release_o, .tone_output_pin_o);

   // 40 mhz system clock
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   // count watchdog pulses at the edge so negedge readers never race it
   always @(posedge clk_i) if (chip_reset_o === 1'b1) n_rst++;

   // galois shift register, fixed start so every run repeats
   function automatic logic [31:0] rnd();
      lfsr_q = lfsr_q[0] ? ((lfsr_q >> 1) ^ 32'h8020_0003) : (lfsr_q >> 1);
      return lfsr_q;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask

   task automatic rng(input int v, input int lo, input int hi, input string m);
      n_tests++;
      if (v < lo || v > hi) begin
         n_mismatch++;
         $display("unexpected at %0t: %s took %0d", $time, m, v);
      end
   endtask

   // one-cycle strobe, raised and dropped on falling edges
   task automatic pulse(ref logic s);
      @(negedge clk_i);
      s = 1'b1;
      @(negedge clk_i);
      s = 1'b0;
   endtask

   task automatic wait_ev(input logic [7:0] m, output int c);
      c = 0;
      while ((event_flags_o & m) !== m && c < 4000) begin
         @(negedge clk_i);
         c++;
      end
      if (c >= 4000) begin
         n_mismatch++;
         test_done();
      end
   endtask

   // cycles until the tone pin next changes; 600 means it stood still
   task automatic gap(output int c);
      logic t;
      t = tone_output_pin_o;
      c = 0;
      while (tone_output_pin_o === t && c < 600) begin
         @(negedge clk_i);
         c++;
      end
   endtask

   // cycles until a watchdog pulse, or lim if none came
   task automatic wd(input int lim, output int c);
      int s;
      s = n_rst;
      c = 0;
      while (n_rst == s && c < lim) begin
         @(negedge clk_i);
         c++;
      end
   endtask

   task automatic reset_dut();
      rst_i = 1'b1;
      repeat (5) @(negedge clk_i);
      rst_i = 1'b0;
      chk({chip_reset_o, tone_output_pin_o}, 8'h00, "reset pins");
      chk(event_flags_o, EVF_RST, "reset flags");
   endtask

   // timer b: stop, select source, immediate load, time the first underflow
   task automatic tb_meas(input logic [3:0] md, input logic [7:0] pv, input int div);
      int c;
      mode_wdata_i = md;
      pulse(mode_b_we_i);
      tb_imm_data_i = pv;
      pulse(tb_imm_we_i);
      chk(event_flags_o & EVF_TB_MASK, 8'h00, "b imm");
      if (md[MODE_B_EXT]) begin
         for (c = 1; c < 300 && event_flags_o[7] !== 1'b1; c++) begin
            ext_count_input_i = 1'b0;
            repeat (3) @(negedge clk_i);
            ext_count_input_i = 1'b1;
            repeat (3) @(negedge clk_i);
         end
         rng(c - 1, pv + 1, pv + 1, "b ext edges");
      end else begin
         wait_ev(EVF_TB_MASK, c);
         rng(c, pv * div + 1, (pv + 1) * div + 2, "b interval");
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      {wdt_option_i, watchdog_clear_instr_i, pmf_set_i, pmf_clr_i, pmf_mask_i} = '0;
      {mode_a_we_i, mode_b_we_i, mode_wdata_i, ta_nib_lo_we_i, ta_nib_hi_we_i} = '0;
      {tb_nib_lo_we_i, tb_nib_hi_we_i, nib_data_i, tb_imm_we_i, tb_imm_data_i} = '0;
      {event_clear_instr_i, evf_clr_mask_i, irq_ack_i, tone_gen_i} = '0;
      {irq_enable_flags_i, hold_release_enable_i} = '0;
      ext_count_input_i = 1'b1;
      reset_dut();
      // timer a one-shot: preset zero, random presets, then the slow clock
      for (k = 0; k < 4; k++) begin
         r = rnd();
         p = (k == 0) ? 8'h00 : {4'h0, (k == 3) ? 4'h1 : r[3:0]};
         irq_enable_flags_i = r[15:8];
         hold_release_enable_i = r[23:16];
         nib_data_i = p[3:0];
         pulse(ta_nib_lo_we_i);
         nib_data_i = p[7:4];
         pulse(ta_nib_hi_we_i);
         mode_wdata_i = {1'b1, r[25:24], k == 3};
         pulse(mode_a_we_i);
         chk(event_flags_o & EVF_TA_MASK, 8'h00, "a start");
         wait_ev(EVF_TA_MASK, n);
         rng(n, (k == 3 ? 1024 : 4) * p + 1, (k == 3 ? 1024 : 4) * (p + 1) + 6, "a time");
         chk(irq_pending_o, EVF_TA_MASK & r[15:8], "a irq");
         chk(hold_release_o, EVF_TA_MASK & r[23:16], "a hold");
         if (k == 0) begin
            irq_ack_i = EVF_TA_MASK;
            @(negedge clk_i);
            irq_ack_i = 8'h00;
            chk(event_flags_o, 8'h00, "a ack");
            repeat (1100) @(negedge clk_i);
            chk(event_flags_o, 8'h00, "a one shot");
         end
      end
      // a nibble load in mid-count must stop timer a for good
      evf_clr_mask_i = 8'hff;
      pulse(event_clear_instr_i);
      chk(event_flags_o, 8'h00, "clear all");
      nib_data_i = 4'h4;
      pulse(ta_nib_hi_we_i);
      mode_wdata_i = 4'h8;
      pulse(mode_a_we_i);
      repeat (40) @(negedge clk_i);
      nib_data_i = 4'h0;
      pulse(ta_nib_lo_we_i);
      repeat (400) @(negedge clk_i);
      chk(event_flags_o, 8'h00, "a halted");
      $display("timer a done");
      r = rnd();
      tb_meas(4'h0, r[7:0], 1);
      tb_meas(4'h1, {5'h00, r[10:8]}, 64);
      tb_meas(4'h2, {4'h0, r[15:12]}, 1);
      // tone from the reload buffer, then a nibble write halts it
      for (k = 0; k < 2; k++) begin
         r = rnd();
         p = (k == 0) ? 8'h00 : r[7:0];
         nib_data_i = p[3:0];
         pulse(tb_nib_lo_we_i);
         nib_data_i = p[7:4];
         pulse(tb_nib_hi_we_i);
         mode_wdata_i = 4'hc;
         pulse(mode_b_we_i);
         chk(event_flags_o & EVF_TB_MASK, 8'h00, "b run");
         gap(n);
         gap(n);
         rng(n, p + 1, p + 1, "tone half");
         gap(n);
         rng(n, p + 1, p + 1, "tone reload");
         chk(event_flags_o & EVF_TB_MASK, EVF_TB_MASK, "b flag");
         chk(irq_pending_o & EVF_TB_MASK, irq_enable_flags_i & EVF_TB_MASK, "b irq");
         chk(hold_release_o & EVF_TB_MASK, hold_release_enable_i & EVF_TB_MASK, "b hold");
         pulse(tb_nib_hi_we_i);
         evf_clr_mask_i = EVF_TB_MASK;
         pulse(event_clear_instr_i);
         gap(n);
         rng(n, 600, 600, "b halted");
         chk(event_flags_o & EVF_TB_MASK, 8'h00, "b halted flag");
      end
      // with the tone select clear the other waveform reaches the pin
      mode_wdata_i = 4'h0;
      pulse(mode_b_we_i);
      repeat (4) begin
         r = rnd();
         tone_gen_i = r[0];
         @(negedge clk_i);
         chk(tone_output_pin_o, r[0], "tone path");
      end
      $display("timer b done");
      // watchdog: off, then cleared in time, then left to overflow
      wd(17 * 1024, n);
      rng(n, 17 * 1024, 17 * 1024, "wd off");
      wdt_option_i = 1'b1;
      pulse(watchdog_clear_instr_i);
      wd(6000, n);
      rng(n, 6000, 6000, "wd early");
      pulse(watchdog_clear_instr_i);
      k = n_rst;
      wd(17 * 1024, n);
      rng(n, 15 * 1024 - 1, 16 * 1024 + 2, "wd overflow");
      repeat (3) @(negedge clk_i);
      rng(n_rst - k, 1, 1, "wd pulse");
      reset_dut();
      // slow input outlasts the fast span; clearing the flag restores it
      r = rnd();
      pmf_mask_i = {1'b1, r[2:0]};
      pulse(pmf_set_i);
      pulse(watchdog_clear_instr_i);
      wd(17 * 1024, n);
      rng(n, 17 * 1024, 17 * 1024, "wd slow");
      pulse(pmf_clr_i);
      pulse(watchdog_clear_instr_i);
      wd(17 * 1024, n);
      rng(n, 15 * 1024 - 1, 16 * 1024 + 2, "wd fast again");
      $display("watchdog done");
      test_done();
   end
endmodule // testbench
